// file: core/corr_input_pkg.sv
// constants and types for the correlator input routing block
package corr_input_pkg;

	// timing
	localparam int CYCLE_NS = 150;
	localparam int MCLK_PS = 5000;
	localparam int CYCLE_CNT = (CYCLE_NS * 1000) / MCLK_PS;
	localparam int HALF_CNT = CYCLE_CNT / 2;

	// widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int SMP_W = 8;
	localparam int NUM_MULT = 4;
	localparam int TEST_DEPTH = 512;
	localparam int TEST_AW = $clog2(TEST_DEPTH);

	// register map (word index)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_DISP = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_VALID_ADDR = 4'h3;
	localparam logic [3:0] REG_EXP_IN = 4'h4;

	// control fields
	localparam int CTRL_MIXED_BIT = 0;
	localparam int CTRL_TEST_BIT = 1;
	localparam int CTRL_EXP_EN_BIT = 2;
	localparam int CTRL_DISP_SUB_BIT = 3;
	localparam int CTRL_W = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam logic [DATA_W-1:0] DISP_RESET = 16'h0000;

	// status fields
	localparam int STAT_EXT_BIT = 0;
	localparam int STAT_MIXED_BIT = 1;
	localparam int STAT_PHASE2_BIT = 2;
	localparam int STAT_TEST_BIT = 3;
	localparam int STAT_REQ_BIT = 4;

	// operand select codes
	localparam logic [2:0] SEL_A_X_SAMPLE = 3'h0;
	localparam logic [2:0] SEL_A_Y_SAMPLE = 3'h1;
	localparam logic [2:0] SEL_A_X_EXP = 3'h2;
	localparam logic [2:0] SEL_A_Y_EXP = 3'h3;
	localparam logic [2:0] SEL_A_ONE = 3'h4;
	localparam logic [1:0] SEL_B_X_SAMPLE = 2'h0;
	localparam logic [1:0] SEL_B_Y_SAMPLE = 2'h1;
	localparam logic [1:0] SEL_B_X_EXP = 2'h2;
	localparam logic [1:0] SEL_B_Y_EXP = 2'h3;
	localparam logic [SMP_W-1:0] OPERAND_ONE = 8'h01;

	typedef enum logic [2:0] {
		ADDR_NORMAL = 3'b001,
		ADDR_MIXED = 3'b010,
		ADDR_EXTERNAL = 3'b100
	} addr_mode_t;

endpackage

// file: core/corr_input_routing.sv
// input routing, address source selection and operand capture
`timescale 1ns/1ps
`default_nettype none

module corr_input_routing
	import corr_input_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// sequencer controls, same clock
	input wire logic [ADDR_W-1:0] primary_buffer_address,
	input wire logic exp_capture,
	input wire logic [3*NUM_MULT-1:0] sel_a,
	input wire logic [2*NUM_MULT-1:0] sel_b,
	input wire logic [NUM_MULT-1:0] stb_a,
	input wire logic [NUM_MULT-1:0] stb_b,
	input wire logic ext_addr_send,
	input wire logic [ADDR_W-1:0] ext_addr_value,
	input wire logic ext_data_send,
	// pins
	input wire logic external_request,
	input wire logic [DATA_W-1:0] buffer_data,
	input wire logic [DATA_W-1:0] test_data,
	output logic [TEST_AW-1:0] test_address,
	input wire logic [ADDR_W-1:0] expansion_address_bus_in,
	output logic [ADDR_W-1:0] expansion_address_bus_out,
	output logic expansion_address_bus_oe,
	input wire logic [DATA_W-1:0] expansion_data_bus_in,
	output logic [DATA_W-1:0] expansion_data_bus_out,
	output logic expansion_data_bus_oe,
	// results
	output logic system_clock,
	output logic phase1_end,
	output logic phase2_end,
	output logic [ADDR_W-1:0] valid_buffer_address,
	output logic [ADDR_W-1:0] displaced_buffer_address,
	output logic [DATA_W-1:0] sample_input_bus,
	output logic [DATA_W-1:0] exp_input_q,
	output logic [SMP_W*NUM_MULT-1:0] operand_a,
	output logic [SMP_W*NUM_MULT-1:0] operand_b,
	output logic external_mode
);

	localparam logic [4:0] CYCLE_LAST = 5'(CYCLE_CNT - 1);
	localparam logic [4:0] HALF_LAST = 5'(HALF_CNT - 1);

	////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic req_s1_q, req_s2_q;
	logic [DATA_W-1:0] buf_s1_q, buf_s2_q;
	logic [DATA_W-1:0] test_s1_q, test_s2_q;
	logic [DATA_W-1:0] edb_s1_q, edb_s2_q;
	logic [ADDR_W-1:0] eab_s1_q, eab_s2_q;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
		end else begin
			req_s1_q <= external_request;
			req_s2_q <= req_s1_q;
		end
	end

	// data pins carry no reset: values are only looked at once settled
	always_ff @(posedge mclk) begin
		buf_s1_q <= buffer_data;
		buf_s2_q <= buf_s1_q;
		test_s1_q <= test_data;
		test_s2_q <= test_s1_q;
		edb_s1_q <= expansion_data_bus_in;
		edb_s2_q <= edb_s1_q;
		eab_s1_q <= expansion_address_bus_in;
		eab_s2_q <= eab_s1_q;
	end

	////////////////////////////////////////////////////////////////
	// system cycle divider: phase 1 is the first half, phase 2 the second

	logic [4:0] ph_cnt_q, ph_cnt_d;
	logic in_phase2;
	logic end_ph1;
	logic end_ph2;

	assign end_ph1 = (ph_cnt_q == HALF_LAST);
	assign end_ph2 = (ph_cnt_q == CYCLE_LAST);
	assign in_phase2 = (ph_cnt_q > HALF_LAST);
	assign ph_cnt_d = end_ph2 ? 5'h00 : ph_cnt_q + 5'h01;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ph_cnt_q <= 5'h00;
		end else begin
			ph_cnt_q <= ph_cnt_d;
		end
	end

	assign phase1_end = end_ph1;
	assign phase2_end = end_ph2;

	logic sys_clk_q;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sys_clk_q <= 1'b0;
		end else begin
			sys_clk_q <= ~ph_cnt_d[4] & (ph_cnt_d <= HALF_LAST);
		end
	end

	assign system_clock = sys_clk_q;

	////////////////////////////////////////////////////////////////
	// register port

	logic [CTRL_W-1:0] ctrl_q;
	logic [DATA_W-1:0] disp_q;
	logic wr_ctrl, wr_disp;

	assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
	assign wr_disp = reg_wr && (reg_addr == REG_DISP);

	// only the host reaches these; the sequencer has no path to them
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ctrl_q <= CTRL_RESET;
			disp_q <= DISP_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata[CTRL_W-1:0];
			end
			if (wr_disp) begin
				disp_q <= reg_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// control fields take effect on cycle boundaries only,
	// so a control write never splits a system cycle; a disp_q write applies at once

	logic cfg_mixed_q, cfg_test_q, cfg_exp_en_q, cfg_sub_q;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cfg_mixed_q <= 1'b0;
			cfg_test_q <= 1'b0;
			cfg_exp_en_q <= 1'b0;
			cfg_sub_q <= 1'b0;
		end else if (end_ph2) begin
			cfg_mixed_q <= ctrl_q[CTRL_MIXED_BIT];
			cfg_test_q <= ctrl_q[CTRL_TEST_BIT];
			cfg_exp_en_q <= ctrl_q[CTRL_EXP_EN_BIT];
			cfg_sub_q <= ctrl_q[CTRL_DISP_SUB_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// address source mode

	addr_mode_t mode_q, mode_d;
	addr_mode_t base_mode;

	assign base_mode = cfg_mixed_q ? ADDR_MIXED : ADDR_NORMAL;

	// the configured mode is never overwritten, so dropping the request
	// falls straight back to it
	always_comb begin
		case (mode_q)
			ADDR_NORMAL, ADDR_MIXED: begin
				mode_d = req_s2_q ? ADDR_EXTERNAL : base_mode;
			end
			ADDR_EXTERNAL: begin
				mode_d = req_s2_q ? ADDR_EXTERNAL : base_mode;
			end
			default: begin
				mode_d = ADDR_NORMAL;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			mode_q <= ADDR_NORMAL;
		end else if (end_ph2) begin
			mode_q <= mode_d;
		end
	end

	assign external_mode = (mode_q == ADDR_EXTERNAL);

	////////////////////////////////////////////////////////////////
	// address generation

	logic [ADDR_W-1:0] disp_addr;
	logic [ADDR_W-1:0] vab_sel;
	logic [ADDR_W-1:0] vab_q;
	logic [ADDR_W-1:0] disp_addr_q;

	assign disp_addr = cfg_sub_q ? primary_buffer_address - disp_q
		: primary_buffer_address + disp_q;

	always_comb begin
		case (mode_q)
			ADDR_NORMAL: vab_sel = primary_buffer_address;
			ADDR_MIXED: vab_sel = in_phase2 ? primary_buffer_address : disp_addr;
			ADDR_EXTERNAL: vab_sel = eab_s2_q;
			default: vab_sel = primary_buffer_address;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			vab_q <= '0;
			disp_addr_q <= '0;
		end else begin
			vab_q <= vab_sel;
			disp_addr_q <= disp_addr;
		end
	end

	assign valid_buffer_address = vab_q;
	assign displaced_buffer_address = disp_addr_q;

	////////////////////////////////////////////////////////////////
	// sample input bus source

	logic [DATA_W-1:0] sib_q;
	logic [TEST_AW-1:0] test_addr_q;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sib_q <= '0;
			test_addr_q <= '0;
		end else begin
			sib_q <= cfg_test_q ? test_s2_q : buf_s2_q;
			test_addr_q <= primary_buffer_address[TEST_AW-1:0];
		end
	end

	assign sample_input_bus = sib_q;
	assign test_address = test_addr_q;

	////////////////////////////////////////////////////////////////
	// expansion input register

	logic exp_from_sib;
	logic exp_load;
	logic [DATA_W-1:0] exp_q;

	// in mixed mode the displaced sample arrives on the sample bus in phase 1;
	// this leans on the buffer memory settling within the half cycle
	assign exp_from_sib = (mode_q == ADDR_MIXED) && cfg_exp_en_q;
	assign exp_load = end_ph1 && exp_capture;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			exp_q <= '0;
		end else if (exp_load) begin
			exp_q <= exp_from_sib ? sib_q : edb_s2_q;
		end
	end

	assign exp_input_q = exp_q;

	////////////////////////////////////////////////////////////////
	// expansion bus drivers, started and stopped each system cycle

	logic eab_oe_q, edb_oe_q;
	logic [ADDR_W-1:0] eab_out_q;
	logic [DATA_W-1:0] edb_out_q;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			eab_oe_q <= 1'b0;
			edb_oe_q <= 1'b0;
			eab_out_q <= '0;
			edb_out_q <= '0;
		end else if (end_ph2) begin
			// never drive the address bus while it is our address source
			eab_oe_q <= ext_addr_send && (mode_d != ADDR_EXTERNAL);
			edb_oe_q <= ext_data_send;
			eab_out_q <= ext_addr_value;
			edb_out_q <= sib_q;
		end
	end

	assign expansion_address_bus_out = eab_out_q;
	assign expansion_address_bus_oe = eab_oe_q;
	assign expansion_data_bus_out = edb_out_q;
	assign expansion_data_bus_oe = edb_oe_q;

	////////////////////////////////////////////////////////////////
	// operand registers, one A and one B per multiplier

	logic [SMP_W-1:0] x_sib, y_sib, x_exp, y_exp;

	assign x_sib = sib_q[SMP_W-1:0];
	assign y_sib = sib_q[DATA_W-1:SMP_W];
	assign x_exp = exp_q[SMP_W-1:0];
	assign y_exp = exp_q[DATA_W-1:SMP_W];

	genvar m;
	generate
		for (m = 0; m < NUM_MULT; m++) begin : g_mult
			logic [2:0] a_code;
			logic [1:0] b_code;
			logic [SMP_W-1:0] a_q, b_q;
			logic [SMP_W-1:0] a_d, b_d;
			logic a_hold;

			assign a_code = sel_a[3*m +: 3];
			assign b_code = sel_b[2*m +: 2];

			// unused A codes keep the old value rather than load garbage
			always_comb begin
				a_hold = 1'b0;
				case (a_code)
					SEL_A_X_SAMPLE: a_d = x_sib;
					SEL_A_Y_SAMPLE: a_d = y_sib;
					SEL_A_X_EXP: a_d = x_exp;
					SEL_A_Y_EXP: a_d = y_exp;
					SEL_A_ONE: a_d = OPERAND_ONE;
					default: begin
						a_d = a_q;
						a_hold = 1'b1;
					end
				endcase
			end

			always_comb begin
				case (b_code)
					SEL_B_X_SAMPLE: b_d = x_sib;
					SEL_B_Y_SAMPLE: b_d = y_sib;
					SEL_B_X_EXP: b_d = x_exp;
					SEL_B_Y_EXP: b_d = y_exp;
					default: b_d = b_q;
				endcase
			end

			always_ff @(posedge mclk) begin
				if (!nrst) begin
					a_q <= '0;
					b_q <= '0;
				end else if (end_ph2) begin
					if (stb_a[m] && !a_hold) begin
						a_q <= a_d;
					end
					if (stb_b[m]) begin
						b_q <= b_d;
					end
				end
			end

			assign operand_a[SMP_W*m +: SMP_W] = a_q;
			assign operand_b[SMP_W*m +: SMP_W] = b_q;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// read back

	logic [DATA_W-1:0] status_word;
	logic [DATA_W-1:0] rd_mux;
	logic [DATA_W-1:0] rdata_q;

	always_comb begin
		status_word = '0;
		status_word[STAT_EXT_BIT] = external_mode;
		status_word[STAT_MIXED_BIT] = (mode_q == ADDR_MIXED);
		status_word[STAT_PHASE2_BIT] = in_phase2;
		status_word[STAT_TEST_BIT] = cfg_test_q;
		status_word[STAT_REQ_BIT] = req_s2_q;
	end

	always_comb begin
		case (reg_addr)
			REG_CTRL: rd_mux = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
			REG_DISP: rd_mux = disp_q;
			REG_STATUS: rd_mux = status_word;
			REG_VALID_ADDR: rd_mux = vab_q;
			REG_EXP_IN: rd_mux = exp_q;
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

// file: test/corr_far_side.sv
// far side model: buffer memory, test store and expansion bus devices
`timescale 1ns/1ps
`default_nettype none
module corr_far_side
	import corr_input_pkg::*;
(
	input wire logic [ADDR_W-1:0] valid_buffer_address,
	input wire logic [TEST_AW-1:0] test_address,
	input wire logic [ADDR_W-1:0] expansion_address_bus_out,
	input wire logic expansion_address_bus_oe,
	input wire logic [DATA_W-1:0] expansion_data_bus_out,
	input wire logic expansion_data_bus_oe,
	input wire logic [ADDR_W-1:0] dev_addr,
	input wire logic [DATA_W-1:0] dev_data,
	output logic [DATA_W-1:0] buffer_data,
	output logic [DATA_W-1:0] test_data,
	output logic [ADDR_W-1:0] expansion_address_bus_in,
	output logic [DATA_W-1:0] expansion_data_bus_in
);
////////////////////////////////////////
// memory answers at once, far inside the half-cycle limit
assign buffer_data = ~valid_buffer_address;
assign test_data = {7'h2a, test_address};
// two-way lines: whoever enables wins, else the device drives
assign expansion_address_bus_in = expansion_address_bus_oe ? expansion_address_bus_out : dev_addr;
assign expansion_data_bus_in = expansion_data_bus_oe ? expansion_data_bus_out : dev_data;
endmodule
`default_nettype wire

// file: test/corr_input_monitor.sv
// assertion checker on the input routing ports
`timescale 1ns/1ps
`default_nettype none
module corr_input_monitor
	import corr_input_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic exp_capture,
	input wire logic [3*NUM_MULT-1:0] sel_a,
	input wire logic [NUM_MULT-1:0] stb_a,
	input wire logic [NUM_MULT-1:0] stb_b,
	input wire logic [ADDR_W-1:0] primary_buffer_address,
	input wire logic [ADDR_W-1:0] expansion_address_bus_in,
	input wire logic expansion_address_bus_oe,
	input wire logic system_clock,
	input wire logic phase1_end,
	input wire logic phase2_end,
	input wire logic [ADDR_W-1:0] valid_buffer_address,
	input wire logic [DATA_W-1:0] exp_input_q,
	input wire logic [SMP_W*NUM_MULT-1:0] operand_a,
	input wire logic [SMP_W*NUM_MULT-1:0] operand_b,
	input wire logic external_mode
);
default clocking dc @(posedge mclk); endclocking
default disable iff (!nrst);
////////////////////////////////////////
sequence half_s;
	phase1_end ##15 phase2_end;
endsequence
sequence fall_s;
	system_clock ##1 !system_clock;
endsequence
cycle_len_a: assert property (phase2_end |-> ##30 phase2_end) else $error("cycle length");
half_len_a: assert property (phase1_end |-> half_s) else $error("phase length");
clk_fall_a: assert property (phase1_end |-> fall_s) else $error("clock phase");
exp_hold_a: assert property (!(phase1_end && exp_capture) |=> $stable(exp_input_q))
	else $error("expansion register moved");
opnd_hold_a: assert property (!(phase2_end && (|stb_a || |stb_b)) |=>
	$stable(operand_a) && $stable(operand_b)) else $error("operand moved");
one_load_a: assert property (phase2_end && stb_a[0] && sel_a[2:0] == SEL_A_ONE |=>
	operand_a[7:0] == OPERAND_ONE) else $error("constant load");
phase2_addr_a: assert property ($past(nrst) && !system_clock &&
	!$past(system_clock) && !external_mode |->
	valid_buffer_address == $past(primary_buffer_address)) else $error("phase 2 address");
ext_addr_a: assert property (external_mode && $past(external_mode, 4) |->
	valid_buffer_address == $past(expansion_address_bus_in, 3)) else $error("external address");
eab_quiet_a: assert property (external_mode |-> !expansion_address_bus_oe)
	else $error("address bus driven");
endmodule
bind corr_input_routing corr_input_monitor u_corr_input_monitor (.mclk, .nrst, .exp_capture,
	.sel_a, .stb_a, .stb_b, .primary_buffer_address, .expansion_address_bus_in,
	.expansion_address_bus_oe, .system_clock, .phase1_end, .phase2_end, .valid_buffer_address,
	.exp_input_q, .operand_a, .operand_b, .external_mode);
`default_nettype wire

// file: test/corr_input_routing_tb.sv
// self-checking bench for the input routing block
`timescale 1ns/1ps
`default_nettype none
module corr_input_routing_tb
	import corr_input_pkg::*;
;
logic mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, exp_capture = 1'b0;
logic ext_addr_send = 1'b0, ext_data_send = 1'b0, external_request = 1'b0;
logic [3:0] reg_addr = 4'h0;
logic [3*NUM_MULT-1:0] sel_a = 12'h000;
logic [2*NUM_MULT-1:0] sel_b = 8'h00;
logic [NUM_MULT-1:0] stb_a = 4'h0, stb_b = 4'h0;
logic [15:0] reg_wdata = 16'h0000, dev_data = 16'hc3a5, dev_addr = 16'h5e21;
logic [15:0] ext_addr_value = 16'h0000, primary_buffer_address = 16'h1234;
logic [15:0] reg_rdata, buffer_data, test_data, expansion_address_bus_in, exp_input_q;
logic [15:0] expansion_address_bus_out, expansion_data_bus_in, expansion_data_bus_out;
logic [15:0] valid_buffer_address, displaced_buffer_address, sample_input_bus;
logic [TEST_AW-1:0] test_address;
logic [31:0] operand_a, operand_b;
logic expansion_address_bus_oe, expansion_data_bus_oe, system_clock, phase1_end, phase2_end;
logic external_mode;
int err_total = 0, compares = 0;
////////////////////////////////////////
corr_input_routing u_corr_input_routing (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .primary_buffer_address, .exp_capture, .sel_a, .sel_b, .stb_a, .stb_b,
	.ext_addr_send, .ext_addr_value, .ext_data_send, .external_request, .buffer_data,
	.test_data, .test_address, .expansion_address_bus_in, .expansion_address_bus_out,
	.expansion_address_bus_oe, .expansion_data_bus_in, .expansion_data_bus_out,
	.expansion_data_bus_oe, .system_clock, .phase1_end, .phase2_end, .valid_buffer_address,
	.displaced_buffer_address, .sample_input_bus, .exp_input_q, .operand_a, .operand_b,
	.external_mode);
corr_far_side u_corr_far_side (.valid_buffer_address, .test_address, .expansion_address_bus_out,
	.expansion_address_bus_oe, .expansion_data_bus_out, .expansion_data_bus_oe, .dev_addr,
	.dev_data, .buffer_data, .test_data, .expansion_address_bus_in, .expansion_data_bus_in);
initial begin
	forever #2.5 mclk = ~mclk;
end
////////////////////////////////////////
task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
	compares++;
	if (seen !== exp) begin
		err_total++;
		$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
	end
endtask
task automatic summarize;
	if (err_total == 0 && compares > 0) $display("*** PASS ***");
	else $display("*** FAIL ***");
	$finish;
endtask
task automatic wr(logic [3:0] a, logic [15:0] d);
	@(posedge mclk);
	reg_addr <= a;
	reg_wdata <= d;
	reg_wr <= 1'b1;
	@(posedge mclk);
	reg_wr <= 1'b0;
endtask
task automatic rd(logic [3:0] a, logic [15:0] e);
	@(posedge mclk);
	reg_addr <= a;
	reg_rd <= 1'b1;
	@(posedge mclk);
	reg_rd <= 1'b0;
	@(posedge mclk);
	check("rdata", reg_rdata, e);
endtask
// returns at the edge that starts count n; outputs sampled there show count n-1
task automatic at(int n);
	do @(posedge mclk); while (phase2_end !== 1'b1);
	repeat (n) @(posedge mclk);
endtask
function automatic logic [7:0] src(int c);
	logic [15:0] s;
	s = c[1] ? dev_data : ~primary_buffer_address;
	if (c >= 4) return OPERAND_ONE;
	return c[0] ? s[15:8] : s[7:0];
endfunction
////////////////////////////////////////
initial begin
	repeat (6) @(posedge mclk);
	nrst <= 1'b1;
	rd(REG_CTRL, CTRL_RESET);
	rd(4'hf, 16'h0000);
	check("oe", {expansion_address_bus_oe, expansion_data_bus_oe, external_mode}, 16'h0000);
	at(6);
	check("vab", valid_buffer_address, 16'h1234);
	check("dib", sample_input_bus, 16'hedcb);
	at(14);
	exp_capture <= 1'b1;
	@(posedge mclk);
	exp_capture <= 1'b0;
	@(posedge mclk);
	check("expq", exp_input_q, dev_data);
	wr(REG_CTRL, 16'h0002);
	at(0);
	at(10);
	check("test", sample_input_bus, {7'h2a, 9'h034});
	check("taddr", test_address, 16'h0034);
	wr(REG_DISP, 16'h0010);
	wr(REG_CTRL, 16'h0001);
	rd(REG_DISP, 16'h0010);
	rd(REG_CTRL, 16'h0001);
	at(0);
	at(6);
	check("vab1", valid_buffer_address, 16'h1244);
	check("disp", displaced_buffer_address, 16'h1244);
	at(21);
	check("vab2", valid_buffer_address, 16'h1234);
	wr(REG_CTRL, 16'h000d);
	at(0);
	at(6);
	check("dsub", displaced_buffer_address, 16'h1224);
	at(14);
	exp_capture <= 1'b1;
	at(29);
	exp_capture <= 1'b0;
	sel_a <= {4{SEL_A_X_EXP}};
	sel_b <= {4{SEL_B_X_SAMPLE}};
	stb_a <= 4'h1;
	stb_b <= 4'h1;
	at(1);
	stb_a <= 4'h0;
	stb_b <= 4'h0;
	check("mixq", exp_input_q, 16'heddb);
	check("mixab", {operand_a[7:0], operand_b[7:0]}, 16'hdbcb);
	rd(REG_EXP_IN, 16'heddb);
	// ask to drive the address bus while external: must stay released
	ext_addr_send <= 1'b1;
	external_request <= 1'b1;
	at(0);
	at(0);
	at(11);
	check("extm", {15'h0000, external_mode}, 16'h0001);
	check("vabx", valid_buffer_address, dev_addr);
	check("eaboff", {15'h0000, expansion_address_bus_oe}, 16'h0000);
	rd(REG_STATUS, 16'h0011);
	rd(REG_VALID_ADDR, dev_addr);
	ext_addr_send <= 1'b0;
	external_request <= 1'b0;
	at(0);
	at(0);
	at(6);
	check("back", valid_buffer_address, 16'h1224);
	wr(REG_CTRL, 16'h0000);
	at(0);
	// exp register still holds a mixed-mode sample: reload it from the data bus
	at(14);
	exp_capture <= 1'b1;
	@(posedge mclk);
	exp_capture <= 1'b0;
	@(posedge mclk);
	check("expq2", exp_input_q, dev_data);
	for (int c = 0; c < 6; c++) begin
		at(29);
		sel_a <= {4{c[2:0]}};
		sel_b <= {4{c[1:0]}};
		stb_a <= 4'hf;
		stb_b <= 4'hf;
		at(1);
		stb_a <= 4'h0;
		stb_b <= 4'h0;
		check("opa", operand_a[15:0], {2{src(c)}});
		check("opb", operand_b[31:16], {2{src(c & 3)}});
	end
	at(29);
	sel_a <= {4{SEL_A_X_SAMPLE}};
	stb_a <= 4'h4;
	at(1);
	stb_a <= 4'h0;
	check("own", operand_a[31:16], {OPERAND_ONE, src(0)});
	check("rest", operand_a[15:0], {2{OPERAND_ONE}});
	at(29);
	ext_addr_send <= 1'b1;
	ext_data_send <= 1'b1;
	ext_addr_value <= 16'h0777;
	at(1);
	ext_addr_send <= 1'b0;
	ext_data_send <= 1'b0;
	check("eab", expansion_address_bus_out, 16'h0777);
	check("edb", expansion_data_bus_out, 16'hedcb);
	check("oes", {expansion_address_bus_oe, expansion_data_bus_oe}, 16'h0003);
	at(1);
	check("oes0", {expansion_address_bus_oe, expansion_data_bus_oe}, 16'h0000);
	summarize();
end
initial begin
	#50000;
	err_total++;
	summarize();
end
endmodule
`default_nettype wire
